// ### verilog/css_pkg.sv
`default_nettype none
package css_pkg;
    localparam int NUM_CH = 2;
    localparam int CLK_PERIOD_NS = 25;
    // internal sync pulse period, kept in its own unit
    localparam real SYNC_PERIOD_US = 62.5;
    localparam int SYNC_CYCLES = int'(SYNC_PERIOD_US * 1000.0 / real'(CLK_PERIOD_NS));
    localparam logic [11:0] SYNC_LAST = 12'(SYNC_CYCLES - 1);
    localparam logic [31:0] TICK_NS = 32'(CLK_PERIOD_NS);

    typedef logic [7:0] css_idx_t;
    // parameter indices, one per channel
    localparam css_idx_t MODE_IDX [NUM_CH] = '{8'h3e, 8'h58};
    localparam css_idx_t ARM_IDX [NUM_CH] = '{8'h40, 8'h5a};
    localparam css_idx_t PRE_EDGE_IDX [NUM_CH] = '{8'h44, 8'h5e};
    localparam css_idx_t PRE_SRC_IDX [NUM_CH] = '{8'h48, 8'h62};
    localparam css_idx_t FLAG_IDX [NUM_CH] = '{8'h4a, 8'h64};
    localparam css_idx_t TIME_IDX [NUM_CH] = '{8'h4c, 8'h66};
    localparam css_idx_t TRIG_IDX [NUM_CH] = '{8'h4e, 8'h68};
    localparam css_idx_t PREFILT_IDX [NUM_CH] = '{8'h50, 8'h6a};

    // source codes and value limits
    localparam logic [7:0] SRC_RS485_FIRST = 8'h07;
    localparam logic [7:0] SRC_IDX_PRI = 8'h0a;
    localparam logic [7:0] SRC_IDX_TER = 8'h0b;
    localparam logic [7:0] SRC_MAX = 8'h0b;
    localparam logic [7:0] PREFILT_MAX = 8'h02;
    localparam logic [7:0] MODE_MAX = 8'h03;
    localparam logic [7:0] MODE_TIME = 8'h01;
    localparam logic [7:0] EDGE_RISE = 8'h01;
    localparam logic [7:0] EDGE_FALL = 8'h02;
    localparam logic [7:0] EDGE_BOTH = 8'h03;
    localparam logic [31:0] TIME_RESET = 32'h0000_0000;

    typedef struct packed {
        logic [6:0] gen;
        logic [2:0] rs485;
        logic idx_pri;
        logic idx_ter;
    } css_src_t;

    typedef struct packed {
        logic arm;
        logic [7:0] mode;
        logic [7:0] pre_src;
        logic [7:0] trig_src;
        logic [7:0] pre_edge;
        logic [7:0] prefilter;
    } css_cfg_t;

    typedef struct packed {
        logic flag;
        logic pre_pulse;
        logic [31:0] time_ns;
    } css_stat_t;

    localparam css_cfg_t CFG_RESET = '{arm: 1'b0, mode: 8'h00, pre_src: 8'h00,
        trig_src: 8'h00, pre_edge: EDGE_RISE, prefilter: 8'h00};
endpackage
`default_nettype wire

// ### verilog/css_channel.sv
`timescale 1ns/100ps
`default_nettype none
module css_channel (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire css_pkg::css_cfg_t cfg,
    input wire css_pkg::css_src_t src,
    input wire logic [31:0] time_now,
    output css_pkg::css_stat_t stat
);
    import css_pkg::*;

    logic trig_cur;
    logic pre_cur;
    logic trig_prev_reg;
    logic pre_prev_reg;
    logic arm_prev_reg;
    logic trig_rise;
    logic arm_rise;
    logic capture;
    logic pre_hit;
    logic flag_reg;
    logic pre_pulse_reg;
    logic [31:0] time_reg;

    // shared decode for both selectors; unlisted codes give a quiet low
    function automatic logic pick(input css_src_t s, input logic [7:0] code,
                                  input logic ter_ok);
        logic [7:0] off;
        off = code - SRC_RS485_FIRST;
        if (code < SRC_RS485_FIRST) begin
            pick = s.gen[code[2:0]];
        end else if (code < SRC_IDX_PRI) begin
            pick = s.rs485[off[1:0]];
        end else if (code == SRC_IDX_PRI) begin
            pick = s.idx_pri;
        end else if (code == SRC_IDX_TER && ter_ok) begin
            pick = s.idx_ter;
        end else begin
            pick = 1'b0;
        end
    endfunction

    // precondition has no tertiary index, trigger does
    assign pre_cur = pick(src, cfg.pre_src, 1'b0);
    assign trig_cur = pick(src, cfg.trig_src, 1'b1);
    assign trig_rise = trig_cur && !trig_prev_reg;
    assign arm_rise = cfg.arm && !arm_prev_reg;
    // a trigger in the arming cycle still counts, so the old flag is ignored then
    assign capture = cfg.arm && trig_rise && (!stat.flag || arm_rise);

    // edge code 0 is reserved and detects nothing
    always_comb begin
        case (cfg.pre_edge)
            EDGE_RISE: pre_hit = pre_cur && !pre_prev_reg;
            EDGE_FALL: pre_hit = !pre_cur && pre_prev_reg;
            EDGE_BOTH: pre_hit = pre_cur != pre_prev_reg;
            default: pre_hit = 1'b0;
        endcase
    end

    // edge history
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            trig_prev_reg <= 1'b0;
            pre_prev_reg <= 1'b0;
            arm_prev_reg <= 1'b0;
            pre_pulse_reg <= 1'b0;
        end else begin
            trig_prev_reg <= trig_cur;
            pre_prev_reg <= pre_cur;
            arm_prev_reg <= cfg.arm;
            pre_pulse_reg <= pre_hit;
        end
    end

    // captured flag: set wins over the clear from arming
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            flag_reg <= 1'b0;
        end else if (capture) begin
            flag_reg <= 1'b1;
        end else if (arm_rise) begin
            flag_reg <= 1'b0;
        end
    end

    // time stamp only in time capture mode; other modes keep the old value
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            time_reg <= TIME_RESET;
        end else if (capture && cfg.mode == MODE_TIME) begin
            time_reg <= time_now;
        end
    end

    // one driver for the whole status word, each field straight from its flop
    assign stat = '{flag: flag_reg, pre_pulse: pre_pulse_reg, time_ns: time_reg};

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_flag_clear_arm: assert property (
        arm_rise && !capture |=> !stat.flag)
        else $error("flag not cleared on arming");
    a_flag_set_capture: assert property (
        cfg.arm && trig_rise && !stat.flag |=> stat.flag)
        else $error("flag not set by capture");
    a_flag_holds_low: assert property (
        !stat.flag && !capture |=> !stat.flag)
        else $error("flag rose without capture");
    a_time_stamp_now: assert property (
        capture && cfg.mode == MODE_TIME |=> stat.time_ns == $past(time_now))
        else $error("time result not stamped");
    a_time_held_still: assert property (
        !(capture && cfg.mode == MODE_TIME) |=> $stable(stat.time_ns))
        else $error("time result changed without capture");
    a_pre_rise_seen: assert property (
        cfg.pre_edge == EDGE_RISE && pre_cur && !pre_prev_reg |=> stat.pre_pulse)
        else $error("precondition rise missed");
    a_pre_code_quiet: assert property (
        (cfg.pre_src == SRC_IDX_TER) [*2] |=> !stat.pre_pulse)
        else $error("unlisted precondition code produced an edge");
    a_trig_gen_one: assert property (
        cfg.trig_src == 8'h00 && cfg.arm && !stat.flag && $rose(src.gen[0]) |=> stat.flag)
        else $error("general input 1 trigger missed");
endmodule // css_channel
`default_nettype wire

// ### verilog/css_top.sv
`timescale 1ns/100ps
`default_nettype none
module css_top (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [6:0] gen_in,
    input wire logic [2:0] rs485_in,
    input wire logic index_primary,
    input wire logic index_tertiary,
    input wire css_pkg::css_idx_t reg_addr,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_rd_valid,
    output logic reg_err,
    output logic periodic_sync_pulse,
    output logic [1:0] capture_flag,
    output logic [1:0] precondition_edge_pulse
);
    import css_pkg::*;

    css_src_t src_meta_reg;
    css_src_t src_sync_reg;
    css_cfg_t cfg_reg [NUM_CH];
    css_stat_t stat [NUM_CH];
    logic [11:0] sync_cnt_reg;
    logic [31:0] time_ns_reg;
    logic sync_now;
    logic [31:0] rdata_next;
    logic hit_next;

    // pins cross into core_clk through two stages
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            src_meta_reg <= '0;
            src_sync_reg <= '0;
        end else begin
            src_meta_reg <= '{gen: gen_in, rs485: rs485_in, idx_pri: index_primary,
                              idx_ter: index_tertiary};
            src_sync_reg <= src_meta_reg;
        end
    end

    // periodic sync divider and the nanosecond time base it restarts
    assign sync_now = sync_cnt_reg == SYNC_LAST;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sync_cnt_reg <= 12'h000;
            time_ns_reg <= TIME_RESET;
            periodic_sync_pulse <= 1'b0;
        end else if (sync_now) begin
            sync_cnt_reg <= 12'h000;
            time_ns_reg <= TIME_RESET;
            periodic_sync_pulse <= 1'b1;
        end else begin
            sync_cnt_reg <= sync_cnt_reg + 12'h001;
            time_ns_reg <= time_ns_reg + TICK_NS;
            periodic_sync_pulse <= 1'b0;
        end
    end

    // parameter writes; out-of-range values are dropped, keeping the old setting
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            for (int c = 0; c < NUM_CH; c++) begin
                cfg_reg[c] <= CFG_RESET;
            end
        end else if (reg_wr_en) begin
            for (int c = 0; c < NUM_CH; c++) begin
                if (reg_addr == PRE_SRC_IDX[c] && reg_wdata[7:0] <= SRC_MAX) begin
                    cfg_reg[c].pre_src <= reg_wdata[7:0];
                end
                if (reg_addr == TRIG_IDX[c] && reg_wdata[7:0] <= SRC_MAX) begin
                    cfg_reg[c].trig_src <= reg_wdata[7:0];
                end
                if (reg_addr == PREFILT_IDX[c] && reg_wdata[7:0] <= PREFILT_MAX) begin
                    cfg_reg[c].prefilter <= reg_wdata[7:0];
                end
                if (reg_addr == MODE_IDX[c] && reg_wdata[7:0] <= MODE_MAX) begin
                    cfg_reg[c].mode <= reg_wdata[7:0];
                end
                if (reg_addr == PRE_EDGE_IDX[c] && reg_wdata[7:0] <= EDGE_BOTH) begin
                    cfg_reg[c].pre_edge <= reg_wdata[7:0];
                end
                if (reg_addr == ARM_IDX[c]) begin
                    cfg_reg[c].arm <= reg_wdata[0];
                end
            end
        end
    end

    // read decode; flag and time are read-only, writes to them are ignored
    always_comb begin
        rdata_next = 32'h0000_0000;
        hit_next = 1'b0;
        for (int c = 0; c < NUM_CH; c++) begin
            if (reg_addr == PRE_SRC_IDX[c]) begin
                rdata_next = {24'h00_0000, cfg_reg[c].pre_src};
                hit_next = 1'b1;
            end else if (reg_addr == TRIG_IDX[c]) begin
                rdata_next = {24'h00_0000, cfg_reg[c].trig_src};
                hit_next = 1'b1;
            end else if (reg_addr == PREFILT_IDX[c]) begin
                rdata_next = {24'h00_0000, cfg_reg[c].prefilter};
                hit_next = 1'b1;
            end else if (reg_addr == MODE_IDX[c]) begin
                rdata_next = {24'h00_0000, cfg_reg[c].mode};
                hit_next = 1'b1;
            end else if (reg_addr == PRE_EDGE_IDX[c]) begin
                rdata_next = {24'h00_0000, cfg_reg[c].pre_edge};
                hit_next = 1'b1;
            end else if (reg_addr == ARM_IDX[c]) begin
                rdata_next = {31'h0000_0000, cfg_reg[c].arm};
                hit_next = 1'b1;
            end else if (reg_addr == FLAG_IDX[c]) begin
                rdata_next = {31'h0000_0000, stat[c].flag};
                hit_next = 1'b1;
            end else if (reg_addr == TIME_IDX[c]) begin
                rdata_next = stat[c].time_ns;
                hit_next = 1'b1;
            end
        end
    end

    // registered read answer, one cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0000_0000;
            reg_rd_valid <= 1'b0;
            reg_err <= 1'b0;
        end else begin
            reg_rd_valid <= reg_rd_en;
            reg_err <= (reg_rd_en || reg_wr_en) && !hit_next;
            reg_rdata <= reg_rd_en ? rdata_next : 32'h0000_0000;
        end
    end

    // channels share only the synced inputs and the time base
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        css_channel u_ch (
            .core_clk(core_clk),
            .rst_n(rst_n),
            .cfg(cfg_reg[g]),
            .src(src_sync_reg),
            .time_now(time_ns_reg),
            .stat(stat[g])
        );
        assign capture_flag[g] = stat[g].flag;
        assign precondition_edge_pulse[g] = stat[g].pre_pulse;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_sync_time_zero: assert property (
        periodic_sync_pulse |-> time_ns_reg == TIME_RESET && sync_cnt_reg == 12'h000)
        else $error("time base not restarted by sync");
    a_sync_spacing: assert property (
        periodic_sync_pulse |-> $past(sync_cnt_reg) == SYNC_LAST)
        else $error("sync pulse spacing wrong");
    a_pre_src_range: assert property (
        reg_wr_en && reg_addr == PRE_SRC_IDX[0] && reg_wdata[7:0] > SRC_MAX
        |=> $stable(cfg_reg[0].pre_src))
        else $error("out-of-range precondition code accepted");
    a_prefilt_range: assert property (
        reg_wr_en && reg_addr == PREFILT_IDX[1] && reg_wdata[7:0] > PREFILT_MAX
        |=> $stable(cfg_reg[1].prefilter))
        else $error("out-of-range prefilter accepted");
endmodule // css_top
`default_nettype wire

// ### test/css_far_side.sv
`timescale 1ns/100ps
`default_nettype none
// far-side pins, one line per source code so the bench can speak in selector codes
module css_far_side (
    input wire logic [11:0] lines,
    output logic [6:0] gen_in,
    output logic [2:0] rs485_in,
    output logic index_primary,
    output logic index_tertiary
);
    // plain level wires; the bench only moves lines on a clock edge, the design syncs them
    assign gen_in = lines[6:0];
    assign rs485_in = lines[9:7];
    assign index_primary = lines[10];
    assign index_tertiary = lines[11];
endmodule // css_far_side
`default_nettype wire

// ### test/capture_source_select_status_test.sv
`timescale 1ns/100ps
`default_nettype none
`define CHECK(what, exp, got) begin total_checks++; if ((got) !== (exp)) begin miscompares++; $display("mismatch %s expected %0h seen %0h", what, exp, got); end end
module capture_source_select_status_test;
    import css_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] lines = 12'h000;
    css_idx_t reg_addr = 8'h00;
    logic reg_wr_en = 1'b0;
    logic reg_rd_en = 1'b0;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic [31:0] reg_rdata;
    logic reg_rd_valid;
    logic reg_err;
    logic periodic_sync_pulse;
    logic [1:0] capture_flag;
    logic [1:0] precondition_edge_pulse;
    logic [6:0] gen_in;
    logic [2:0] rs485_in;
    logic index_primary;
    logic index_tertiary;
    logic [31:0] rd;
    logic [31:0] t0;
    logic err;
    logic seen;
    logic seen1;
    int miscompares = 0;
    int total_checks = 0;
    int cyc = 0;
    int s0;
    int s;
    int f;

    css_far_side partner (.lines(lines), .gen_in(gen_in), .rs485_in(rs485_in),
        .index_primary(index_primary), .index_tertiary(index_tertiary));
    css_top dut (.core_clk(core_clk), .rst_n(rst_n), .gen_in(gen_in), .rs485_in(rs485_in),
        .index_primary(index_primary), .index_tertiary(index_tertiary), .reg_addr(reg_addr),
        .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .reg_err(reg_err),
        .periodic_sync_pulse(periodic_sync_pulse), .capture_flag(capture_flag),
        .precondition_edge_pulse(precondition_edge_pulse));

    // 40 MHz
    always #12.5 core_clk = ~core_clk;

    // cycle count, also the hang guard; the whole run needs well under half this
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // one-cycle strobe, taken at the second edge
    task automatic reg_write(input css_idx_t a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr_en <= 1'b1;
        @(posedge core_clk);
        reg_wr_en <= 1'b0;
    endtask

    // answer lands one cycle after the strobe edge; sampled once it has settled
    task automatic reg_read(input css_idx_t a, output logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd_en <= 1'b1;
        @(posedge core_clk);
        reg_rd_en <= 1'b0;
        #1;
        `CHECK("read valid", 1'b1, reg_rd_valid)
        d = reg_rdata;
        err = reg_err;
    endtask

    task automatic expect_reg(input string what, input css_idx_t a, input logic [31:0] exp);
        reg_read(a, rd);
        `CHECK(what, exp, rd)
        `CHECK("read err", 1'b0, err)
    endtask

    task automatic drive(input logic [11:0] v);
        @(posedge core_clk);
        lines <= v;
    endtask

    // waits n cycles and notes any precondition pulse of channel 0 in seen and of channel 1 in seen1
    task automatic watch(input int n);
        seen = 1'b0;
        seen1 = 1'b0;
        repeat (n) begin
            @(posedge core_clk);
            #1;
            seen |= precondition_edge_pulse[0];
            seen1 |= precondition_edge_pulse[1];
        end
    endtask

    // only a 0 to 1 change of arm clears the flag, so drop it first
    task automatic arm(input int ch);
        reg_write(ARM_IDX[ch], 32'h0000_0000);
        reg_write(ARM_IDX[ch], 32'h0000_0001);
    endtask

    task automatic wait_sync(output int t);
        for (int i = 0; i < 3000; i++) begin
            watch(1);
            if (periodic_sync_pulse === 1'b1) break;
        end
        t = cyc;
    endtask

    initial begin
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        for (int ch = 0; ch < NUM_CH; ch++) begin
            expect_reg("pre source", PRE_SRC_IDX[ch], 32'h0000_0000);
            expect_reg("trig source", TRIG_IDX[ch], 32'h0000_0000);
            expect_reg("prefilter", PREFILT_IDX[ch], 32'h0000_0000);
            expect_reg("flag", FLAG_IDX[ch], 32'h0000_0000);
            reg_write(FLAG_IDX[ch], 32'h0000_0001);
            expect_reg("flag written", FLAG_IDX[ch], 32'h0000_0000);
        end
        // boundary values: highest code kept, one above refused
        reg_write(PRE_SRC_IDX[0], 32'h0000_000c);
        expect_reg("pre source range", PRE_SRC_IDX[0], 32'h0000_0000);
        reg_write(PRE_SRC_IDX[1], 32'h0000_000b);
        reg_write(PRE_SRC_IDX[1], 32'h0000_000c);
        expect_reg("pre source max", PRE_SRC_IDX[1], 32'h0000_000b);
        reg_write(TRIG_IDX[1], 32'h0000_000c);
        expect_reg("trig source range", TRIG_IDX[1], 32'h0000_0000);
        reg_write(PREFILT_IDX[1], 32'h0000_0002);
        reg_write(PREFILT_IDX[1], 32'h0000_0003);
        expect_reg("prefilter max", PREFILT_IDX[1], 32'h0000_0002);
        reg_read(8'h00, rd);
        `CHECK("unmapped err", 1'b1, err)
        // every trigger code: other sources must not fire, the chosen one must
        reg_write(MODE_IDX[0], 32'(MODE_TIME));
        reg_write(MODE_IDX[0], 32'h0000_0004);
        expect_reg("mode range", MODE_IDX[0], 32'h0000_0001);
        for (int c = 0; c < 12; c++) begin
            reg_write(TRIG_IDX[0], 32'(c));
            arm(0);
            watch(2);
            `CHECK("flag after arm", 1'b0, capture_flag[0])
            drive(~(12'h001 << c));
            watch(6);
            `CHECK("flag other source", 1'b0, capture_flag[0])
            drive(12'hfff);
            watch(6);
            `CHECK("flag selected", 1'b1, capture_flag[0])
            `CHECK("flag other channel", 1'b0, capture_flag[1])
            drive(12'h000);
            watch(4);
        end
        reg_write(TRIG_IDX[1], 32'h0000_000b);
        arm(1);
        drive(12'h800);
        watch(6);
        expect_reg("flag channel 1", FLAG_IDX[1], 32'h0000_0001);
        drive(12'h000);
        // time stamp relative to the last sync pulse
        reg_write(TRIG_IDX[0], 32'h0000_0000);
        arm(0);
        wait_sync(s0);
        wait_sync(s);
        `CHECK("sync period", 32'h0000_09c4, 32'(s - s0))
        watch(100);
        drive(12'h001);
        for (int i = 0; i < 20 && capture_flag[0] !== 1'b1; i++) watch(1);
        f = cyc;
        `CHECK("flag time capture", 1'b1, capture_flag[0])
        t0 = 32'((f - 1 - s) * 25);
        expect_reg("time stamp", TIME_IDX[0], t0);
        drive(12'h000);
        watch(3);
        drive(12'h001);
        watch(6);
        expect_reg("single shot", TIME_IDX[0], t0);
        reg_write(MODE_IDX[0], 32'h0000_0000);
        drive(12'h000);
        arm(0);
        drive(12'h001);
        watch(6);
        `CHECK("flag mode 0", 1'b1, capture_flag[0])
        expect_reg("time kept mode 0", TIME_IDX[0], t0);
        drive(12'h000);
        watch(4);
        // every precondition code with rising edge; code 11 has no input
        for (int c = 0; c < 12; c++) begin
            reg_write(PRE_SRC_IDX[0], 32'(c));
            drive(~(12'h001 << c));
            watch(6);
            `CHECK("pre other", 1'b0, seen)
            drive(12'hfff);
            watch(6);
            `CHECK("pre selected", c < 11, seen)
            `CHECK("pre other channel", 1'b0, seen1)
            drive(12'h000);
            watch(6);
            `CHECK("pre fall on rise code", 1'b0, seen)
        end
        reg_write(PRE_SRC_IDX[0], 32'h0000_0000);
        for (int e = 2; e < 4; e++) begin
            reg_write(PRE_EDGE_IDX[0], 32'(e));
            drive(12'h001);
            watch(6);
            `CHECK("pre rise", e == 3, seen)
            drive(12'h000);
            watch(6);
            `CHECK("pre fall", 1'b1, seen)
        end
        // reserved edge code detects nothing; channel 1 sees the shared inputs too
        reg_write(PRE_EDGE_IDX[0], 32'h0000_0000);
        reg_write(PRE_SRC_IDX[1], 32'h0000_0000);
        drive(12'h001);
        watch(6);
        `CHECK("pre reserved", 1'b0, seen)
        `CHECK("pre channel 1", 1'b1, seen1)
        finish_test();
    end
endmodule // capture_source_select_status_test
`default_nettype wire
